//--- design/ssr_register_bank.sv
// Register bank of the sensor, behind a byte-wide serial engine port.
`timescale 1ns/1ps
module ssr_register_bank #(
   // Identity codes; the values are arbitrary.
   parameter logic [11:0] CHIP_TYPE = 12'h0ab,
   parameter logic [3:0]  CHIP_REV  = 4'h3
) (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       srst,
   // Serial engine side.
   input  wire logic       idxLoad,
   input  wire logic [7:0] idxByte,
   input  wire logic       wrStrobe,
   input  wire logic [7:0] wrData,
   input  wire logic       rdStrobe,
   output logic [7:0]      rdData,
   output logic [6:0]      curIndex,
   // Sensor core side.
   input  wire logic       frameStart,
   input  wire logic       timingTaken,
   input  wire logic       clkDivTaken,
   input  wire logic       gainTaken,
   input  wire logic       longTaken,
   input  wire logic       shortTaken,
   input  wire logic       darkValid,
   input  wire logic [9:0] darkMean,
   output logic [7:0]      power_and_timing_setup,
   output logic [7:0]      misc_setup,
   output logic [7:0]      grabberModes,
   output logic [6:0]      pinOverride,
   output logic [7:0]      readoutOrder,
   output logic [6:0]      outputCoding,
   output logic [9:0]      shortExposure,
   output logic [9:0]      longExposure,
   output logic [3:0]      amplifierGain,
   output logic [3:0]      pixelClockDiv,
   output logic [10:0]     blackOffset,
   output logic [2:0]      blackOffsetCtrl,
   output logic [9:0]      rowPeriod,
   output logic [9:0]      framePeriod,
   output logic [3:0]      soundSetup,
   output logic [7:0]      statusFlags,
   output logic [7:0]      frameTally
);
   logic       autoInc_q;
   logic [7:0] rdNext;
   logic       wr;

   // Index register; the engine strobes one pulse per acknowledged byte.
   always_ff @(posedge clk) begin
      if (srst) begin
         curIndex  <= 7'h00;
         autoInc_q <= 1'b0;
      end else if (idxLoad) begin
         curIndex  <= idxByte[6:0];
         autoInc_q <= idxByte[7];
      end else if ((wrStrobe || rdStrobe) && autoInc_q) begin
         curIndex  <= curIndex + 7'd1;
      end
   end

   assign wr = wrStrobe && !idxLoad;

   // Writable registers; unlisted and status indexes fall through.
   always_ff @(posedge clk) begin
      if (srst) begin
         power_and_timing_setup          <= ssr_pkg::RST_POWER_AND_TIMING_SETUP;
         misc_setup          <= ssr_pkg::RST_MISC_SETUP;
         grabberModes    <= 8'h00;
         pinOverride     <= 7'h00;
         readoutOrder    <= 8'h00;
         outputCoding    <= ssr_pkg::RST_CODING[6:0];
         shortExposure   <= 10'h000;
         longExposure    <= ssr_pkg::RST_LONG;
         amplifierGain   <= 4'h0;
         pixelClockDiv   <= ssr_pkg::RST_CLK_DIV;
         blackOffset     <= 11'h000;
         blackOffsetCtrl <= ssr_pkg::RST_BOFS_CTRL[2:0];
         rowPeriod       <= ssr_pkg::RST_ROW;
         framePeriod     <= ssr_pkg::RST_FRM;
         soundSetup      <= ssr_pkg::RST_SOUND;
      end else if (wr) begin
         case (curIndex)
            ssr_pkg::IDX_POWER_AND_TIMING_SETUP:     power_and_timing_setup <= wrData;
            ssr_pkg::IDX_MISC_SETUP:     misc_setup <= wrData;
            ssr_pkg::IDX_GRABBER_SIGNAL_MODES:   grabberModes <= wrData;
            ssr_pkg::IDX_PIN_OVR:    pinOverride <= wrData[6:0];
            ssr_pkg::IDX_READOUT:    readoutOrder <= wrData;
            ssr_pkg::IDX_CODING:     outputCoding <= wrData[6:0];
            ssr_pkg::IDX_SHORT_HIGH: shortExposure[9:8] <= wrData[1:0];
            ssr_pkg::IDX_SHORT_LOW:  shortExposure[7:0] <= wrData;
            ssr_pkg::IDX_LONG_HIGH:  longExposure[9:8] <= wrData[1:0];
            ssr_pkg::IDX_LONG_LOW:   longExposure[7:0] <= wrData;
            ssr_pkg::IDX_GAIN:       amplifierGain <= wrData[3:0];
            ssr_pkg::IDX_CLK_DIV:    pixelClockDiv <= wrData[3:0];
            ssr_pkg::IDX_BOFS_HIGH:  blackOffset[10:8] <= wrData[2:0];
            ssr_pkg::IDX_BOFS_LOW:   blackOffset[7:0] <= wrData;
            ssr_pkg::IDX_BOFS_CTRL:  blackOffsetCtrl <= wrData[2:0];
            ssr_pkg::IDX_ROW_HIGH:   rowPeriod[9:8] <= wrData[1:0];
            ssr_pkg::IDX_ROW_LOW:    rowPeriod[7:0] <= wrData;
            ssr_pkg::IDX_FRM_HIGH:   framePeriod[9:8] <= wrData[1:0];
            ssr_pkg::IDX_FRM_LOW:    framePeriod[7:0] <= wrData;
            ssr_pkg::IDX_SOUND:      soundSetup <= wrData[3:0];
            default: ;
         endcase
      end
   end

   // Write and take events of the five pending flags; element 4 stands
   // for the timing flag, elements 3 to 0 for the status bits of the
   // same number.
   logic [4:0] pendSet;
   logic [4:0] pendTake;
   logic [4:0] pendCur;
   logic [4:0] pendNext;

   // A write to either byte of an exposure or period pair marks the whole value pending.
   assign pendSet[4] = wr && (curIndex == ssr_pkg::IDX_ROW_HIGH ||
                              curIndex == ssr_pkg::IDX_ROW_LOW ||
                              curIndex == ssr_pkg::IDX_FRM_HIGH ||
                              curIndex == ssr_pkg::IDX_FRM_LOW);
   assign pendSet[3] = wr && curIndex == ssr_pkg::IDX_CLK_DIV;
   assign pendSet[2] = wr && curIndex == ssr_pkg::IDX_GAIN;
   assign pendSet[1] = wr && (curIndex == ssr_pkg::IDX_LONG_HIGH ||
                              curIndex == ssr_pkg::IDX_LONG_LOW);
   assign pendSet[0] = wr && (curIndex == ssr_pkg::IDX_SHORT_HIGH ||
                              curIndex == ssr_pkg::IDX_SHORT_LOW);
   assign pendTake = {timingTaken, clkDivTaken, gainTaken, longTaken,
                      shortTaken};
   assign pendCur  = {statusFlags[ssr_pkg::ST_TIMING],
                      statusFlags[ssr_pkg::ST_CLKDIV],
                      statusFlags[ssr_pkg::ST_GAIN],
                      statusFlags[ssr_pkg::ST_LONG],
                      statusFlags[ssr_pkg::ST_SHORT]};

   // Set beats take: a value written in the cycle the core takes the old
   // one must still be reported as pending, or it would never be applied.
   for (genvar i = 0; i < 5; i++) begin : g_pend
      assign pendNext[i] = pendSet[i] || (pendCur[i] && !pendTake[i]);
   end

   // Status register; bits 6 and 5 are reserved and always read zero.
   always_ff @(posedge clk) begin
      if (srst) begin
         statusFlags <= {3'b000, ssr_pkg::RST_ODD, 4'h0};
      end else begin
         statusFlags[ssr_pkg::ST_TIMING] <= pendNext[4];
         statusFlags[ssr_pkg::ST_CLKDIV] <= pendNext[3];
         statusFlags[ssr_pkg::ST_GAIN]   <= pendNext[2];
         statusFlags[ssr_pkg::ST_LONG]   <= pendNext[1];
         statusFlags[ssr_pkg::ST_SHORT]  <= pendNext[0];
         if (frameStart)
            statusFlags[ssr_pkg::ST_ODD] <= ~statusFlags[ssr_pkg::ST_ODD];
      end
   end

   // Frame tally wraps naturally at eight bits.
   always_ff @(posedge clk) begin
      if (srst)
         frameTally <= ssr_pkg::RST_FRAME;
      else if (frameStart)
         frameTally <= frameTally + 8'd1;
   end

   // Dark mean held as a signed result from the offset loop.
   logic [9:0] darkMean_q;
   always_ff @(posedge clk) begin
      if (srst)
         darkMean_q <= 10'h000;
      else if (darkValid)
         darkMean_q <= darkMean;
   end

   // Read mux; high bytes pad unused bits with zero.
   always_comb begin
      rdNext = 8'h00;
      case (curIndex)
         ssr_pkg::IDX_ID_HIGH:    rdNext = CHIP_TYPE[11:4];
         ssr_pkg::IDX_ID_LOW:     rdNext = {CHIP_TYPE[3:0], CHIP_REV};
         ssr_pkg::IDX_STATUS:     rdNext = statusFlags;
         ssr_pkg::IDX_DARK_HIGH:  rdNext = {6'h00, darkMean_q[9:8]};
         ssr_pkg::IDX_DARK_LOW:   rdNext = darkMean_q[7:0];
         ssr_pkg::IDX_FRAME:      rdNext = frameTally;
         ssr_pkg::IDX_POWER_AND_TIMING_SETUP:     rdNext = power_and_timing_setup;
         ssr_pkg::IDX_MISC_SETUP:     rdNext = misc_setup;
         ssr_pkg::IDX_GRABBER_SIGNAL_MODES:   rdNext = grabberModes;
         ssr_pkg::IDX_PIN_OVR:    rdNext = {1'b0, pinOverride};
         ssr_pkg::IDX_READOUT:    rdNext = readoutOrder;
         ssr_pkg::IDX_CODING:     rdNext = {1'b0, outputCoding};
         ssr_pkg::IDX_SHORT_HIGH: rdNext = {6'h00, shortExposure[9:8]};
         ssr_pkg::IDX_SHORT_LOW:  rdNext = shortExposure[7:0];
         ssr_pkg::IDX_LONG_HIGH:  rdNext = {6'h00, longExposure[9:8]};
         ssr_pkg::IDX_LONG_LOW:   rdNext = longExposure[7:0];
         ssr_pkg::IDX_GAIN:       rdNext = {4'h0, amplifierGain};
         ssr_pkg::IDX_CLK_DIV:    rdNext = {4'h0, pixelClockDiv};
         ssr_pkg::IDX_BOFS_HIGH:  rdNext = {5'h00, blackOffset[10:8]};
         ssr_pkg::IDX_BOFS_LOW:   rdNext = blackOffset[7:0];
         ssr_pkg::IDX_BOFS_CTRL:  rdNext = {5'h00, blackOffsetCtrl};
         ssr_pkg::IDX_ROW_HIGH:   rdNext = {6'h00, rowPeriod[9:8]};
         ssr_pkg::IDX_ROW_LOW:    rdNext = rowPeriod[7:0];
         ssr_pkg::IDX_FRM_HIGH:   rdNext = {6'h00, framePeriod[9:8]};
         ssr_pkg::IDX_FRM_LOW:    rdNext = framePeriod[7:0];
         ssr_pkg::IDX_SOUND:      rdNext = {4'h0, soundSetup};
         default:                 rdNext = 8'h00;
      endcase
   end

   // Registered read data, always tracking the current index.
   always_ff @(posedge clk) begin
      if (srst)
         rdData <= 8'h00;
      else
         rdData <= rdNext;
   end
endmodule

//--- design/ssr_pkg.sv
// Constants of the sensor status register bank.
package ssr_pkg;
   localparam logic [6:0] IDX_ID_HIGH     = 7'h00;
   localparam logic [6:0] IDX_ID_LOW      = 7'h01;
   localparam logic [6:0] IDX_STATUS      = 7'h02;
   localparam logic [6:0] IDX_DARK_HIGH   = 7'h09;
   localparam logic [6:0] IDX_DARK_LOW    = 7'h0a;
   localparam logic [6:0] IDX_FRAME       = 7'h0e;
   localparam logic [6:0] IDX_POWER_AND_TIMING_SETUP      = 7'h10;
   localparam logic [6:0] IDX_MISC_SETUP      = 7'h11;
   localparam logic [6:0] IDX_GRABBER_SIGNAL_MODES    = 7'h14;
   localparam logic [6:0] IDX_PIN_OVR     = 7'h15;
   localparam logic [6:0] IDX_READOUT     = 7'h16;
   localparam logic [6:0] IDX_CODING      = 7'h17;
   localparam logic [6:0] IDX_SHORT_HIGH  = 7'h20;
   localparam logic [6:0] IDX_SHORT_LOW   = 7'h21;
   localparam logic [6:0] IDX_LONG_HIGH   = 7'h22;
   localparam logic [6:0] IDX_LONG_LOW    = 7'h23;
   localparam logic [6:0] IDX_GAIN        = 7'h24;
   localparam logic [6:0] IDX_CLK_DIV     = 7'h25;
   localparam logic [6:0] IDX_BOFS_HIGH   = 7'h2c;
   localparam logic [6:0] IDX_BOFS_LOW    = 7'h2d;
   localparam logic [6:0] IDX_BOFS_CTRL   = 7'h2e;
   localparam logic [6:0] IDX_ROW_HIGH    = 7'h52;
   localparam logic [6:0] IDX_ROW_LOW     = 7'h53;
   localparam logic [6:0] IDX_FRM_HIGH    = 7'h54;
   localparam logic [6:0] IDX_FRM_LOW     = 7'h55;
   localparam logic [6:0] IDX_SOUND       = 7'h79;
   // Status bit positions.
   localparam int ST_TIMING = 7;
   localparam int ST_ODD    = 4;
   localparam int ST_CLKDIV = 3;
   localparam int ST_GAIN   = 2;
   localparam int ST_LONG   = 1;
   localparam int ST_SHORT  = 0;
   // Reset values.
   localparam logic [7:0] RST_POWER_AND_TIMING_SETUP    = 8'h01;
   localparam logic [7:0] RST_MISC_SETUP    = 8'h80;
   localparam logic [7:0] RST_CODING    = 8'h18;
   localparam logic [9:0] RST_LONG      = 10'h20a;
   localparam logic [9:0] RST_ROW       = 10'h2f9;
   localparam logic [9:0] RST_FRM       = 10'h20b;
   localparam logic [7:0] RST_BOFS_CTRL = 8'h61;
   localparam logic [3:0] RST_SOUND     = 4'h9;
   localparam logic [3:0] RST_CLK_DIV   = 4'h0;
   localparam logic [7:0] RST_FRAME     = 8'h00;
   localparam logic       RST_ODD       = 1'b1;
endpackage

//--- dv/ssr_register_bank_asserts.sv
// Port checker of the sensor status register bank.
`timescale 1ns/1ps
module ssr_register_bank_asserts #(
   parameter logic [11:0] CHIP_TYPE = 12'h0ab
) (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       srst,
   // Engine and core side.
   input wire logic       idxLoad,
   input wire logic [7:0] idxByte,
   input wire logic       wrStrobe,
   input wire logic       rdStrobe,
   input wire logic [6:0] curIndex,
   input wire logic [7:0] rdData,
   input wire logic       frameStart,
   input wire logic       gainTaken,
   input wire logic [7:0] statusFlags,
   input wire logic [7:0] frameTally
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Index handling; a byte transfer may only hold or step the index.
   a_idx_load: assert property (idxLoad |=>
      curIndex == $past(idxByte[6:0])) else $error("index not loaded");
   a_idx_step: assert property ((wrStrobe || rdStrobe) && !idxLoad |=>
      curIndex - $past(curIndex) <= 7'h1) else $error("index jumped");
   a_id_high: assert property (curIndex == ssr_pkg::IDX_ID_HIGH |=>
      rdData == CHIP_TYPE[11:4]) else $error("type code wrong");
   // Frame events drive the counter and the odd/even flag.
   a_frame_count: assert property (frameStart |=>
      frameTally == $past(frameTally) + 8'h01) else $error("count wrong");
   a_odd_toggle: assert property (frameStart |=>
      statusFlags[4] != $past(statusFlags[4])) else $error("no toggle");
   a_odd_hold: assert property (!frameStart |=>
      $stable(statusFlags[4])) else $error("flag moved without frame");
   // A gain write raises its flag; the core taking it clears the flag.
   a_gain_set: assert property (wrStrobe && !idxLoad &&
      curIndex == ssr_pkg::IDX_GAIN |=> statusFlags[2]) else $error("no set");
   a_gain_clear: assert property (gainTaken && !wrStrobe |=>
      !statusFlags[2]) else $error("gain flag stuck");
   // Main scenarios seen.
   c_wrap: cover property (frameStart && frameTally == 8'hff);
   c_gain: cover property (gainTaken && statusFlags[2]);
   c_burst: cover property (wrStrobe && curIndex == 7'h25);
endmodule
bind ssr_register_bank ssr_register_bank_asserts #(.CHIP_TYPE(CHIP_TYPE)) chk (
   .clk(clk), .srst(srst), .idxLoad(idxLoad), .idxByte(idxByte),
   .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .curIndex(curIndex),
   .rdData(rdData), .frameStart(frameStart), .gainTaken(gainTaken),
   .statusFlags(statusFlags), .frameTally(frameTally));

//--- dv/ssr_master_model.sv
// Serial master model driving the bank's byte-level engine port.
`timescale 1ns/1ps
module ssr_master_model (
   // Clock.
   input  wire logic       clk,
   // Engine side.
   output logic            idxLoad,
   output logic [7:0]      idxByte,
   output logic            wrStrobe,
   output logic [7:0]      wrData,
   output logic            rdStrobe,
   input  wire logic [7:0] rdData
);
   // Idle at time zero.
   initial begin
      idxLoad = 1'b0;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      idxByte = 8'h00;
      wrData = 8'h00;
   end
   // One index or data byte; released lines carry junk, not stale data.
   task automatic put(input logic ld, input logic [7:0] b);
      @(negedge clk);
      idxLoad = ld;
      wrStrobe = !ld;
      idxByte = b;
      wrData = b;
      @(negedge clk);
      idxLoad = 1'b0;
      wrStrobe = 1'b0;
      idxByte = ~b;
      wrData = ~b;
   endtask
   // One read byte, acknowledged so the index may step.
   task automatic get(output logic [7:0] d);
      @(negedge clk);
      d = rdData;
      rdStrobe = 1'b1;
      @(negedge clk);
      rdStrobe = 1'b0;
   endtask
endmodule

//--- dv/ssr_register_bank_test.sv
// Self-checking bench of the sensor status register bank.
`timescale 1ns/1ps
module ssr_register_bank_test;
   logic       clk, srst, idxLoad, wrStrobe, rdStrobe, frameStart, darkValid;
   logic       tTim, tClk, tGain, tLong, tShort;
   logic [7:0] idxByte, wrData, rdData, statusFlags, v;
   logic [6:0] curIndex;
   logic [9:0] darkMean;
   logic [7:0] power_and_timing_setup, misc_setup, grabberModes, readoutOrder, frameTally;
   logic [6:0] pinOverride, outputCoding;
   logic [9:0] shortExposure, longExposure, rowPeriod, framePeriod;
   logic [3:0] amplifierGain, pixelClockDiv, soundSetup;
   logic [10:0] blackOffset;
   logic [2:0] blackOffsetCtrl;
   int         fails, n_compared;
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ssr_register_bank #(.CHIP_TYPE(12'h0cd), .CHIP_REV(4'h6)) DUT (
      .clk(clk), .srst(srst), .idxLoad(idxLoad), .idxByte(idxByte),
      .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
      .rdData(rdData), .curIndex(curIndex), .frameStart(frameStart),
      .timingTaken(tTim), .clkDivTaken(tClk), .gainTaken(tGain),
      .longTaken(tLong), .shortTaken(tShort), .darkValid(darkValid),
      .darkMean(darkMean), .power_and_timing_setup(power_and_timing_setup), .misc_setup(misc_setup),
      .grabberModes(grabberModes), .pinOverride(pinOverride),
      .readoutOrder(readoutOrder), .outputCoding(outputCoding),
      .shortExposure(shortExposure), .longExposure(longExposure),
      .amplifierGain(amplifierGain), .pixelClockDiv(pixelClockDiv),
      .blackOffset(blackOffset), .blackOffsetCtrl(blackOffsetCtrl),
      .rowPeriod(rowPeriod), .framePeriod(framePeriod),
      .soundSetup(soundSetup), .statusFlags(statusFlags),
      .frameTally(frameTally));
   ssr_master_model M (.clk(clk), .idxLoad(idxLoad), .idxByte(idxByte),
      .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
      .rdData(rdData));
   // Compare one byte and keep the tallies.
   task automatic cmp(input logic [7:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Compare one packed word of outputs and keep the tallies.
   task automatic cmpW(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t outputs %h want %h", $time, got, exp);
      end
   endtask
   // Every configuration output, packed into four words.
   task automatic cmpCfg(input logic [31:0] e1, e2, e3, e4);
      cmpW({power_and_timing_setup, misc_setup, grabberModes, readoutOrder}, e1);
      cmpW({3'b000, pinOverride, outputCoding, blackOffsetCtrl, soundSetup,
            amplifierGain, pixelClockDiv}, e2);
      cmpW({1'b0, shortExposure, longExposure, blackOffset}, e3);
      cmpW({4'h0, rowPeriod, framePeriod, frameTally}, e4);
   endtask
   // Read one location with the index held, and compare it.
   task automatic chk(input logic [7:0] i, exp);
      M.put(1'b1, i);
      M.get(v);
      cmp(v, exp);
   endtask
   // One-cycle pulse on a core input.
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   // Identity, status and defaults after reset.
   task automatic tReset;
      cmpCfg({8'h01, 8'h80, 8'h00, 8'h00},
             {3'b000, 7'h00, 7'h18, 3'h1, 4'h9, 4'h0, 4'h0},
             {1'b0, 10'h000, 10'h20a, 11'h000},
             {4'h0, 10'h2f9, 10'h20b, 8'h00});
      chk(8'h00, 8'h0c);
      chk(8'h01, 8'hd6);
      chk(8'h02, 8'h10);
      chk(8'h0e, 8'h00);
      chk(8'h11, 8'h80);
      chk(8'h22, 8'h02);
      chk(8'h79, 8'h09);
      $display("reset test done");
   endtask
   // Burst over the exposure group, then the core takes each value.
   task automatic tBurst;
      M.put(1'b1, 8'ha0);
      repeat (6) M.put(1'b0, 8'hff);
      cmp({1'b0, curIndex}, 8'h26);
      cmp(statusFlags, 8'h1f);
      chk(8'h20, 8'h03);
      chk(8'h24, 8'h0f);
      pulse(tGain);
      pulse(tClk);
      pulse(tLong);
      pulse(tShort);
      cmp(statusFlags, 8'h10);
      M.put(1'b1, 8'h53);
      M.put(1'b0, 8'h01);
      cmp(statusFlags, 8'h90);
      pulse(tTim);
      cmp(statusFlags, 8'h10);
      $display("burst test done");
   endtask
   // Writes to status and unused places change nothing.
   task automatic tReadOnly;
      M.put(1'b1, 8'h02);
      M.put(1'b0, 8'hff);
      M.put(1'b1, 8'h03);
      M.put(1'b0, 8'hff);
      chk(8'h02, 8'h10);
      M.get(v);
      cmp(v, 8'h10);
      chk(8'h03, 8'h00);
      $display("read-only test done");
   endtask
   // Every writable register outside the exposure group is written and lands on its output; pin override, offset high and frame high read back.
   task automatic tConfig;
      logic [7:0] b;
      b = 8'hb0;
      M.put(1'b1, 8'h90);
      repeat (8) begin
         M.put(1'b0, b);
         b++;
      end
      M.put(1'b1, 8'hac);
      M.put(1'b0, 8'hfd);
      M.put(1'b0, 8'h4e);
      M.put(1'b0, 8'hfe);
      M.put(1'b1, 8'hd2);
      M.put(1'b0, 8'hfe);
      M.put(1'b0, 8'h11);
      M.put(1'b0, 8'hfd);
      M.put(1'b0, 8'h22);
      M.put(1'b1, 8'h79);
      M.put(1'b0, 8'hf6);
      cmpCfg({8'hb0, 8'hb1, 8'hb4, 8'hb6},
             {3'b000, 7'h35, 7'h37, 3'h6, 4'h6, 4'hf, 4'hf},
             {1'b0, 10'h3ff, 10'h3ff, 11'h54e},
             {4'h0, 10'h211, 10'h122, 8'h00});
      chk(8'h15, 8'h35);
      chk(8'h12, 8'h00);
      chk(8'h2c, 8'h05);
      chk(8'h54, 8'h01);
      cmp(statusFlags, 8'h90);
      pulse(tTim);
      cmp(statusFlags, 8'h10);
      $display("config test done");
   endtask
   // Counter wrap, odd/even flag and a negative dark-line mean.
   task automatic tFrame;
      repeat (257) pulse(frameStart);
      cmp(statusFlags, 8'h00);
      chk(8'h0e, 8'h01);
      cmp(frameTally, 8'h01);
      darkMean = 10'h3c5;
      pulse(darkValid);
      M.put(1'b1, 8'h89);
      M.get(v);
      cmp(v, 8'h03);
      M.get(v);
      cmp(v, 8'hc5);
      $display("frame test done");
   endtask
   // Counts, verdict and end of run.
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog; the whole run needs under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      results;
   end
   // Reset for five cycles, then the scenarios.
   initial begin
      {srst, frameStart, darkValid, tTim, tClk, tGain, tLong, tShort} = 8'hff;
      {frameStart, darkValid, tTim, tClk, tGain, tLong, tShort} = 7'h00;
      darkMean = 10'h000;
      fails = 0;
      n_compared = 0;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      tReset;
      tBurst;
      tReadOnly;
      tConfig;
      tFrame;
      results;
   end
endmodule
